// [pkg/dtc_pkg.sv]
// Constants, encodings and field layout for the dual timer control block.
// Assumes one 125 MHz system clock and a synchronous active-high reset.
// Summary of operation
// R1: Timer-2 enable gates interrupt or skip test.
// R2: Timer-1 enable gates interrupt or skip test.
// R3: External-0 enable gates interrupt or skip test.
// R4: Spare enable bit stores and reads back.
// R5: Unused control bits accept any value harmlessly.
// R6: Reset clears all; back-up keeps trigger, pin.
// R7: Trigger bit 3 gates the trigger pin.
// R8: Trigger bit 2 picks polarity and level.
// R9: Trigger bit 1 picks single or both edges.
// R10: Trigger bit 0 lets pin control timer 1.
// R11: Changing polarity or enable may set flag.
// R12: Prescaler bit write-only; zero stops and initialises.
// R13: Timer-1 bit 3 enables first pulse mode.
// R14: Timer-1 run bit and source select.
// R15: Timer-2 bit 3 enables second pulse mode.
// R16: Timer-2 run bit and source select.
// R17: Pin bit 3 selects shared pin role.
// R18: Transfer instructions write and read registers.
// R19: Pin bit 2 selects timer-1 auto-stop.
// R20: Pin bit 1 selects timer-1 start sync.
// R21: Pin bit 0 picks counted counter-pin-0 edge.
// R22: Timers decrement per event, flag on underflow.
package dtc_pkg;
	// ----------------------------------------
	// Widths and reset values
	// ----------------------------------------
	localparam int REG_W = 4;
	localparam int TMR_W = 8;
	localparam logic [3:0] REG_RST = 4'h0;
	localparam logic PRE_RST = 1'b0;
	localparam logic [7:0] TMR_RST = 8'h00;
	// Prescaler division ratio in system clock cycles.
	localparam int PRESCALE_DIV = 4;
	localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIV - 1);

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int IE_T2_BIT = 3;
	localparam int IE_T1_BIT = 2;
	localparam int IE_SPARE_BIT = 1;
	localparam int IE_EXT0_BIT = 0;
	localparam int TRG_PIN_EN_BIT = 3;
	localparam int TRG_POL_BIT = 2;
	localparam int TRG_BOTH_BIT = 1;
	localparam int TRG_T1CTL_BIT = 0;
	localparam int TMR_PWM_BIT = 3;
	localparam int TMR_RUN_BIT = 2;
	localparam int TMR_SRC_HI = 1;
	localparam int TMR_SRC_LO = 0;
	localparam int PIN_ROLE_BIT = 3;
	localparam int PIN_AUTOSTOP_BIT = 2;
	localparam int PIN_STSYNC_BIT = 1;
	localparam int PIN_EDGE_BIT = 0;

	// ----------------------------------------
	// Count source codes
	// ----------------------------------------
	localparam logic [1:0] T1_SRC_PULSE_MODE_TWO = 2'h0;
	localparam logic [1:0] T1_SRC_PRESC = 2'h1;
	localparam logic [1:0] T1_SRC_PIN1 = 2'h2;
	localparam logic [1:0] T1_SRC_RING = 2'h3;
	localparam logic [1:0] T2_SRC_TIMER_ONE_UNDERFLOW = 2'h0;
	localparam logic [1:0] T2_SRC_PRESC = 2'h1;
	localparam logic [1:0] T2_SRC_PIN0 = 2'h2;
	localparam logic [1:0] T2_SRC_SYS = 2'h3;

	// ----------------------------------------
	// Transfer and skip instructions
	// ----------------------------------------
	typedef enum logic [3:0] {
		DTC_OP_NOP = 4'h0,
		DTC_OP_WR_IRQ_EN = 4'h1,
		DTC_OP_RD_IRQ_EN = 4'h2,
		DTC_OP_WR_TRIG = 4'h3,
		DTC_OP_RD_TRIG = 4'h4,
		DTC_OP_WR_PRESC = 4'h5,
		DTC_OP_WR_TMR1 = 4'h6,
		DTC_OP_RD_TMR1 = 4'h7,
		DTC_OP_WR_TMR2 = 4'h8,
		DTC_OP_RD_TMR2 = 4'h9,
		DTC_OP_WR_PINF = 4'ha,
		DTC_OP_RD_PINF = 4'hb,
		DTC_OP_SKIP_T1 = 4'hc,
		DTC_OP_SKIP_T2 = 4'hd,
		DTC_OP_SKIP_EXT0 = 4'he,
		DTC_OP_SKIP_PIN = 4'hf
	} dtc_op_t;
endpackage

// [pkg/dtc_tmr_if.sv]
// Carrier between the control logic and one down-counting timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface dtc_tmr_if;
	logic tick;
	logic run;
	logic [7:0] reload;
	logic underflow;
	logic wave;
	logic [7:0] count;

	modport ctl
	(
		output tick,
		output run,
		output reload,
		input underflow,
		input wave,
		input count
	);
	modport tmr
	(
		input tick,
		input run,
		input reload,
		output underflow,
		output wave,
		output count
	);
endinterface

// [rtl/dtc_timer.sv]
// One 8-bit down-counting timer with reload and a square wave output.
// Assumes tick is a one-cycle enable on clk_sys from the control logic.
`timescale 1ns/10ps
module dtc_timer
(
	input wire logic clk_sys,
	input wire logic reset,
	dtc_tmr_if.tmr bus
);
	typedef struct packed {
		logic [7:0] count;
		logic wave;
		logic udf;
	} dtc_tmr_state_t;

	dtc_tmr_state_t s_r;
	dtc_tmr_state_t s_nxt;

	// Stopping only masks the tick, so the count is kept while stopped.
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.udf = 1'b0;
		if (bus.run && bus.tick)
		begin
			if (s_r.count == dtc_pkg::TMR_RST)
			begin
				s_nxt.count = bus.reload; // [R22]
				s_nxt.udf = 1'b1; // [R22]
				s_nxt.wave = ~s_r.wave;
			end
			else
			begin
				s_nxt.count = s_r.count - 8'h01; // [R22]
			end
		end
	end

	// State register, cleared by reset.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			s_r <= '0; // [R6]
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign bus.count = s_r.count;
	assign bus.wave = s_r.wave;
	assign bus.underflow = s_r.udf;
endmodule

// [rtl/dtc_top.sv]
// Control registers, trigger pin logic, prescaler and two timers.
// Assumes the CPU issues one instruction strobe at a time on clk_sys.
`timescale 1ns/10ps
module dtc_top
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ram_backup,
	input wire logic xfer_valid,
	input wire logic [3:0] xfer_op,
	input wire logic [3:0] acc_wdata,
	output logic resp_valid,
	output logic [3:0] resp_data,
	output logic resp_skip,
	input wire logic [2:0] irq_ack,
	output logic irq_timer_one,
	output logic irq_timer_two,
	output logic irq_ext_zero,
	input wire logic trig_pin,
	input wire logic counter_pin_zero_i,
	output logic counter_pin_zero_o,
	output logic counter_pin_zero_oe,
	input wire logic counter_pin_one_i,
	output logic port_bit_b_oe_allow,
	input wire logic ring_osc_clk,
	output logic pulse_mode_two_o,
	input wire logic [7:0] timer_one_reload,
	input wire logic [7:0] timer_two_reload,
	output logic [7:0] timer_one_count,
	output logic [7:0] timer_two_count
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [3:0] irq_en;
		logic [3:0] trig_cfg;
		logic presc_run;
		logic [3:0] t1_cfg;
		logic [3:0] t2_cfg;
		logic [3:0] pin_cfg;
		logic [3:0] presc_cnt;
		logic presc_tick;
		logic [2:0] trg_s;
		logic [2:0] pin0_s;
		logic [2:0] pin1_s;
		logic [2:0] ring_s;
		logic trg_norm_prev;
		logic wave2_prev;
		logic t1_started;
		logic flag_t1;
		logic flag_t2;
		logic flag_ext;
		logic resp_valid;
		logic [3:0] resp_data;
		logic resp_skip;
		logic pin0_out;
		logic pulse_mode_two_out;
	} dtc_top_state_t;

	dtc_top_state_t s_r;
	dtc_top_state_t s_nxt;

	dtc_tmr_if t1_if ();
	dtc_tmr_if t2_if ();

	logic trg_norm;
	logic ext_edge;
	logic pin_level_match;
	logic pin0_edge;
	logic pin1_edge;
	logic ring_edge;
	logic pulse_mode_two_edge;
	logic t1_pin_ctl;
	logic t1_sync_sel;
	logic t1_autostop_sel;
	logic t1_tick;
	logic t2_tick;
	logic op_hit;
	dtc_pkg::dtc_op_t op;

	// Edge detect on a synchronised input; bit 1 is the settled sample.
	function automatic logic edge_of(input logic [2:0] s, input logic rising);
		logic e;
		e = rising ? (s[1] & ~s[2]) : (~s[1] & s[2]);
		return e;
	endfunction

	// ----------------------------------------
	// Trigger pin and source edges
	// ----------------------------------------
	// The level is folded with the polarity, so a change of the enable or
	// polarity bit looks like an edge and may set the external flag.
	// A gated pin reads as 0, the reset value, so no false edge follows reset.
	always_comb
	begin
		op = dtc_pkg::dtc_op_t'(xfer_op);
		op_hit = xfer_valid;
		trg_norm = s_r.trig_cfg[dtc_pkg::TRG_PIN_EN_BIT] // [R7]
			& (s_r.trg_s[1] ^ ~s_r.trig_cfg[dtc_pkg::TRG_POL_BIT]); // [R8] [R11]
		if (s_r.trig_cfg[dtc_pkg::TRG_BOTH_BIT])
		begin
			ext_edge = trg_norm ^ s_r.trg_norm_prev; // [R9]
		end
		else
		begin
			ext_edge = trg_norm & ~s_r.trg_norm_prev; // [R9]
		end
		pin_level_match = (s_r.trg_s[1] == s_r.trig_cfg[dtc_pkg::TRG_POL_BIT]); // [R8]
		pin0_edge = edge_of(s_r.pin0_s, s_r.pin_cfg[dtc_pkg::PIN_EDGE_BIT]); // [R21]
		pin1_edge = edge_of(s_r.pin1_s, 1'b1);
		ring_edge = edge_of(s_r.ring_s, 1'b1);
		pulse_mode_two_edge = t2_if.wave & ~s_r.wave2_prev;
		t1_pin_ctl = s_r.trig_cfg[dtc_pkg::TRG_T1CTL_BIT]; // [R10]
		t1_sync_sel = t1_pin_ctl & s_r.pin_cfg[dtc_pkg::PIN_STSYNC_BIT]; // [R20]
		t1_autostop_sel = t1_sync_sel & s_r.pin_cfg[dtc_pkg::PIN_AUTOSTOP_BIT]; // [R19]
	end

	// ----------------------------------------
	// Count source selection
	// ----------------------------------------
	always_comb
	begin
		unique case (s_r.t1_cfg[dtc_pkg::TMR_SRC_HI:dtc_pkg::TMR_SRC_LO])
			dtc_pkg::T1_SRC_PULSE_MODE_TWO: t1_tick = pulse_mode_two_edge; // [R14]
			dtc_pkg::T1_SRC_PRESC: t1_tick = s_r.presc_tick; // [R14]
			dtc_pkg::T1_SRC_PIN1: t1_tick = pin1_edge; // [R14]
			dtc_pkg::T1_SRC_RING: t1_tick = ring_edge; // [R14]
		endcase
		unique case (s_r.t2_cfg[dtc_pkg::TMR_SRC_HI:dtc_pkg::TMR_SRC_LO])
			dtc_pkg::T2_SRC_TIMER_ONE_UNDERFLOW: t2_tick = t1_if.underflow; // [R16] [R22]
			dtc_pkg::T2_SRC_PRESC: t2_tick = s_r.presc_tick; // [R16]
			dtc_pkg::T2_SRC_PIN0: t2_tick = pin0_edge; // [R16]
			dtc_pkg::T2_SRC_SYS: t2_tick = 1'b1; // [R16]
		endcase
	end

	// Run gating; with start sync the timer waits for a trigger edge.
	assign t1_if.tick = t1_tick;
	assign t1_if.run = s_r.t1_cfg[dtc_pkg::TMR_RUN_BIT] // [R14]
		& (~t1_sync_sel | s_r.t1_started); // [R20]
	assign t1_if.reload = timer_one_reload;
	assign t2_if.tick = t2_tick;
	assign t2_if.run = s_r.t2_cfg[dtc_pkg::TMR_RUN_BIT]; // [R16]
	assign t2_if.reload = timer_two_reload;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		// Three flops per external input; bit 2 only remembers the last sample.
		s_nxt.trg_s = {s_r.trg_s[1:0], trig_pin};
		s_nxt.pin0_s = {s_r.pin0_s[1:0], counter_pin_zero_i};
		s_nxt.pin1_s = {s_r.pin1_s[1:0], counter_pin_one_i};
		s_nxt.ring_s = {s_r.ring_s[1:0], ring_osc_clk};
		s_nxt.trg_norm_prev = trg_norm;
		s_nxt.wave2_prev = t2_if.wave;

		// Prescaler: cleared while stopped so it restarts from a known phase.
		s_nxt.presc_tick = 1'b0;
		if (!s_r.presc_run)
		begin
			s_nxt.presc_cnt = 4'h0; // [R12]
		end
		else if (s_r.presc_cnt == dtc_pkg::PRESCALE_LAST)
		begin
			s_nxt.presc_cnt = 4'h0;
			s_nxt.presc_tick = 1'b1; // [R12]
		end
		else
		begin
			s_nxt.presc_cnt = s_r.presc_cnt + 4'h1;
		end

		// Start sync latch, released again on underflow when auto-stop is on.
		if (!t1_sync_sel)
		begin
			s_nxt.t1_started = 1'b0;
		end
		else if (ext_edge)
		begin
			s_nxt.t1_started = 1'b1; // [R20]
		end
		else if (t1_autostop_sel && t1_if.underflow)
		begin
			s_nxt.t1_started = 1'b0; // [R19]
		end

		// Register transfers; every bit is stored as written, except that the prescaler write keeps only bit 0.
		s_nxt.resp_valid = op_hit;
		s_nxt.resp_data = 4'h0;
		s_nxt.resp_skip = 1'b0;
		if (op_hit)
		begin
			unique case (op)
				dtc_pkg::DTC_OP_NOP: s_nxt.resp_data = 4'h0;
				dtc_pkg::DTC_OP_WR_IRQ_EN: s_nxt.irq_en = acc_wdata; // [R18] [R4] [R5]
				dtc_pkg::DTC_OP_RD_IRQ_EN: s_nxt.resp_data = s_r.irq_en; // [R18] [R4]
				dtc_pkg::DTC_OP_WR_TRIG: s_nxt.trig_cfg = acc_wdata; // [R18] [R5]
				dtc_pkg::DTC_OP_RD_TRIG: s_nxt.resp_data = s_r.trig_cfg; // [R18]
				dtc_pkg::DTC_OP_WR_PRESC: s_nxt.presc_run = acc_wdata[0]; // [R12]
				dtc_pkg::DTC_OP_WR_TMR1: s_nxt.t1_cfg = acc_wdata; // [R18]
				dtc_pkg::DTC_OP_RD_TMR1: s_nxt.resp_data = s_r.t1_cfg; // [R18]
				dtc_pkg::DTC_OP_WR_TMR2: s_nxt.t2_cfg = acc_wdata; // [R18]
				dtc_pkg::DTC_OP_RD_TMR2: s_nxt.resp_data = s_r.t2_cfg; // [R18]
				dtc_pkg::DTC_OP_WR_PINF: s_nxt.pin_cfg = acc_wdata; // [R18]
				dtc_pkg::DTC_OP_RD_PINF: s_nxt.resp_data = s_r.pin_cfg; // [R18]
				dtc_pkg::DTC_OP_SKIP_T1: s_nxt.resp_skip =
					s_r.flag_t1 & ~s_r.irq_en[dtc_pkg::IE_T1_BIT]; // [R2]
				dtc_pkg::DTC_OP_SKIP_T2: s_nxt.resp_skip =
					s_r.flag_t2 & ~s_r.irq_en[dtc_pkg::IE_T2_BIT]; // [R1]
				dtc_pkg::DTC_OP_SKIP_EXT0: s_nxt.resp_skip =
					s_r.flag_ext & ~s_r.irq_en[dtc_pkg::IE_EXT0_BIT]; // [R3]
				dtc_pkg::DTC_OP_SKIP_PIN: s_nxt.resp_skip = pin_level_match; // [R8]
			endcase
		end

		// Flags: a skip with its enable off consumes its flag; a new event wins a clear.
		s_nxt.flag_t1 = (s_r.flag_t1 & ~(irq_ack[0] | (op_hit
			&& op == dtc_pkg::DTC_OP_SKIP_T1 && !s_r.irq_en[dtc_pkg::IE_T1_BIT])))
			| t1_if.underflow; // [R22] [R2]
		s_nxt.flag_t2 = (s_r.flag_t2 & ~(irq_ack[1] | (op_hit
			&& op == dtc_pkg::DTC_OP_SKIP_T2 && !s_r.irq_en[dtc_pkg::IE_T2_BIT])))
			| t2_if.underflow; // [R22] [R1]
		s_nxt.flag_ext = (s_r.flag_ext & ~(irq_ack[2] | (op_hit
			&& op == dtc_pkg::DTC_OP_SKIP_EXT0 && !s_r.irq_en[dtc_pkg::IE_EXT0_BIT])))
			| ext_edge; // [R11] [R3]

		// Pin drivers follow the pulse mode enables.
		s_nxt.pin0_out = s_r.t1_cfg[dtc_pkg::TMR_PWM_BIT] & t1_if.wave; // [R13]
		s_nxt.pulse_mode_two_out = s_r.t2_cfg[dtc_pkg::TMR_PWM_BIT] & t2_if.wave; // [R15]

		// Back-up clears only the volatile control registers.
		if (ram_backup)
		begin
			s_nxt.irq_en = dtc_pkg::REG_RST; // [R6]
			s_nxt.t1_cfg = dtc_pkg::REG_RST; // [R6]
			s_nxt.t2_cfg = dtc_pkg::REG_RST; // [R6]
			s_nxt.presc_run = dtc_pkg::PRE_RST; // [R6]
		end
	end

	// State register; reset clears everything including the pin setup.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			s_r <= '0; // [R6]
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Timers
	// ----------------------------------------
	dtc_timer u_timer_one
	(
		.clk_sys(clk_sys),
		.reset(reset),
		.bus(t1_if)
	);

	dtc_timer u_timer_two
	(
		.clk_sys(clk_sys),
		.reset(reset),
		.bus(t2_if)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Interrupt requests are levels until acknowledged or disabled; a skip never clears an enabled flag.
	assign irq_timer_one = s_r.flag_t1 & s_r.irq_en[dtc_pkg::IE_T1_BIT]; // [R2]
	assign irq_timer_two = s_r.flag_t2 & s_r.irq_en[dtc_pkg::IE_T2_BIT]; // [R1]
	assign irq_ext_zero = s_r.flag_ext & s_r.irq_en[dtc_pkg::IE_EXT0_BIT]; // [R3]
	assign resp_valid = s_r.resp_valid;
	assign resp_data = s_r.resp_data;
	assign resp_skip = s_r.resp_skip;
	assign counter_pin_zero_o = s_r.pin0_out;
	assign counter_pin_zero_oe = s_r.pin_cfg[dtc_pkg::PIN_ROLE_BIT]; // [R17]
	assign port_bit_b_oe_allow = ~s_r.pin_cfg[dtc_pkg::PIN_ROLE_BIT]; // [R17]
	assign pulse_mode_two_o = s_r.pulse_mode_two_out;
	assign timer_one_count = t1_if.count;
	assign timer_two_count = t2_if.count;
endmodule

// [bench/dtc_chk.sv]
// Port checker for the dual timer control block.
// Assumes it is bound to dtc_top and sees only that module's ports.
`timescale 1ns/10ps
module dtc_chk
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ram_backup,
	input wire logic xfer_valid,
	input wire logic [3:0] xfer_op,
	input wire logic [3:0] acc_wdata,
	input wire logic resp_valid,
	input wire logic [3:0] resp_data,
	input wire logic resp_skip,
	input wire logic irq_timer_one,
	input wire logic irq_timer_two,
	input wire logic irq_ext_zero,
	input wire logic counter_pin_zero_oe,
	input wire logic port_bit_b_oe_allow,
	input wire logic [7:0] timer_one_count
);
	logic [3:0] ie_r;
	logic run_r;
	// ----------------------------------------
	// Shadow state
	// ----------------------------------------
	// Enable copies taken from the write strobes, since the registers are not ports.
	always_ff @(posedge clk_sys)
	begin
		if (reset || ram_backup)
		begin
			ie_r <= 4'h0;
			run_r <= 1'b0;
		end
		else if (xfer_valid && xfer_op == dtc_pkg::DTC_OP_WR_IRQ_EN)
			ie_r <= acc_wdata;
		else if (xfer_valid && xfer_op == dtc_pkg::DTC_OP_WR_TMR1)
			run_r <= acc_wdata[dtc_pkg::TMR_RUN_BIT];
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// All properties sample on the system clock and stay quiet in reset.
	default clocking dcb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	resp_every_a: assert property (xfer_valid |=> resp_valid)
		else $error("no response after instruction");
	resp_only_a: assert property (!xfer_valid |=> !resp_valid)
		else $error("response without instruction");
	presc_wo_a: assert property (xfer_valid && xfer_op == dtc_pkg::DTC_OP_WR_PRESC
		|=> resp_data == 4'h0) else $error("prescaler write returned data");
	skip_t1_off_a: assert property (xfer_valid && xfer_op == dtc_pkg::DTC_OP_SKIP_T1
		&& ie_r[2] |=> !resp_skip) else $error("timer one skip taken while enabled");
	skip_t2_off_a: assert property (xfer_valid && xfer_op == dtc_pkg::DTC_OP_SKIP_T2
		&& ie_r[3] |=> !resp_skip) else $error("timer two skip taken while enabled");
	skip_ext_off_a: assert property (xfer_valid && xfer_op == dtc_pkg::DTC_OP_SKIP_EXT0
		&& ie_r[0] |=> !resp_skip) else $error("external skip taken while enabled");
	irq_gate_a: assert property ((irq_timer_one |-> ie_r[2]) and (irq_timer_two |-> ie_r[3])
		and (irq_ext_zero |-> ie_r[0])) else $error("interrupt without its enable");
	pin_role_a: assert property (xfer_valid && xfer_op == dtc_pkg::DTC_OP_WR_PINF
		|=> counter_pin_zero_oe == $past(acc_wdata[3]) && port_bit_b_oe_allow != counter_pin_zero_oe)
		else $error("pin role does not follow written bit");
	t1_hold_a: assert property (!run_r |=> $stable(timer_one_count))
		else $error("timer one moved while stopped");
	backup_clear_a: assert property (ram_backup |=> !irq_timer_one && !irq_timer_two
		&& !irq_ext_zero) else $error("interrupt enables survived back-up");
endmodule

bind dtc_top dtc_chk u_chk
(
	.clk_sys(clk_sys), .reset(reset), .ram_backup(ram_backup), .xfer_valid(xfer_valid),
	.xfer_op(xfer_op), .acc_wdata(acc_wdata), .resp_valid(resp_valid), .resp_data(resp_data),
	.resp_skip(resp_skip), .irq_timer_one(irq_timer_one), .irq_timer_two(irq_timer_two),
	.irq_ext_zero(irq_ext_zero), .counter_pin_zero_oe(counter_pin_zero_oe),
	.port_bit_b_oe_allow(port_bit_b_oe_allow), .timer_one_count(timer_one_count)
);

// [bench/dtc_pin_model.sv]
// Model of the pins outside the block: trigger input, counter inputs, oscillator.
// Assumes the bench sets the trigger level and requests counter pulses.
`timescale 1ns/10ps
module dtc_pin_model
(
	input wire logic trig_level,
	input wire logic pulse_req,
	output logic trig_pin,
	output logic counter_pin_zero_i,
	output logic counter_pin_one_i,
	output logic ring_osc_clk
);
	// Board delay keeps pin changes away from the sampling edge.
	assign #2 trig_pin = trig_level;
	assign #2 counter_pin_zero_i = pulse_req;
	assign #2 counter_pin_one_i = pulse_req;
	// The on-chip oscillator runs free at a rate unrelated to the system clock.
	initial ring_osc_clk = 1'b0;
	always #37 ring_osc_clk = ~ring_osc_clk;
endmodule

// [bench/dual_timer_control_regs_test.sv]
// Self-checking bench for the dual timer control block.
// Assumes dtc_top, its package and the pin model are compiled before it.
`timescale 1ns/10ps
module dual_timer_control_regs_test;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic ram_backup = 1'b0;
	logic xfer_valid = 1'b0;
	logic [3:0] xfer_op = 4'h0;
	logic [3:0] acc_wdata = 4'h0;
	logic [2:0] irq_ack = 3'h0;
	logic trig_level = 1'b0;
	logic pulse_req = 1'b0;
	logic [7:0] timer_one_reload = 8'h02;
	logic [7:0] timer_two_reload = 8'h03;
	logic resp_valid, resp_skip, irq_timer_one, irq_timer_two, irq_ext_zero, seen;
	logic trig_pin, counter_pin_zero_i, counter_pin_zero_oe, counter_pin_one_i;
	logic port_bit_b_oe_allow, ring_osc_clk, pulse_mode_two_o, counter_pin_zero_o;
	logic [3:0] resp_data;
	logic [7:0] timer_one_count, timer_two_count, held, held_b;
	int miscompares = 0;
	int num_checks = 0;
	// Rows hold instruction, accumulator value and expected read data.
	logic [11:0] rows [12] = '{12'h1a0, 12'h20a, 12'h360, 12'h406, 12'h6b0, 12'h70b,
		12'h890, 12'h909, 12'hae0, 12'hb0e, 12'h510, 12'h000};
	logic [3:0] rd_ops [5] = '{4'h2, 4'h4, 4'h7, 4'h9, 4'hb};
	logic [3:0] kept [5] = '{4'h0, 4'h6, 4'h0, 4'h0, 4'he};
	wire [4:0] watch = {counter_pin_zero_o, pulse_mode_two_o, irq_ext_zero, irq_timer_two,
		irq_timer_one};

	// Clock of 8 ns period.
	always #4 clk_sys = ~clk_sys;

	dtc_top u_dut
	(
		.clk_sys(clk_sys), .reset(reset), .ram_backup(ram_backup), .xfer_valid(xfer_valid),
		.xfer_op(xfer_op), .acc_wdata(acc_wdata), .resp_valid(resp_valid),
		.resp_data(resp_data), .resp_skip(resp_skip), .irq_ack(irq_ack),
		.irq_timer_one(irq_timer_one), .irq_timer_two(irq_timer_two),
		.irq_ext_zero(irq_ext_zero), .trig_pin(trig_pin),
		.counter_pin_zero_i(counter_pin_zero_i), .counter_pin_zero_o(counter_pin_zero_o),
		.counter_pin_zero_oe(counter_pin_zero_oe), .counter_pin_one_i(counter_pin_one_i),
		.port_bit_b_oe_allow(port_bit_b_oe_allow), .ring_osc_clk(ring_osc_clk),
		.pulse_mode_two_o(pulse_mode_two_o), .timer_one_reload(timer_one_reload),
		.timer_two_reload(timer_two_reload), .timer_one_count(timer_one_count),
		.timer_two_count(timer_two_count)
	);

	dtc_pin_model u_pins
	(
		.trig_level(trig_level), .pulse_req(pulse_req), .trig_pin(trig_pin),
		.counter_pin_zero_i(counter_pin_zero_i), .counter_pin_one_i(counter_pin_one_i),
		.ring_osc_clk(ring_osc_clk)
	);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	// Counts a comparison and reports a mismatch at once.
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Issues one instruction and checks the answer one cycle later.
	task automatic op_chk(input string what, input logic [3:0] op, input logic [3:0] wd,
		input logic [3:0] ed, input logic es);
		@(posedge clk_sys);
		#1;
		xfer_valid = 1'b1;
		xfer_op = op;
		acc_wdata = wd;
		@(posedge clk_sys);
		#1;
		xfer_valid = 1'b0;
		check(what, {3'h0, 1'b1, ed}, {3'h0, resp_valid, resp_data});
		check(what, {7'h1, es}, {6'h0, resp_valid, resp_skip});
	endtask

	// Waits n cycles, noting whether the watched output was ever high.
	task automatic wait_hi(input int sel, input int n, output logic hit);
		hit = 1'b0;
		repeat (n)
		begin
			@(posedge clk_sys);
			#1;
			hit = hit | watch[sel];
		end
	endtask

	// One-cycle flag clear pulse.
	task automatic ack(input logic [2:0] bits);
		@(posedge clk_sys);
		#1;
		irq_ack = bits;
		@(posedge clk_sys);
		#1;
		irq_ack = 3'h0;
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic conclude();
		$display("Checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	// Watchdog sized well above the few hundred cycles the tests need.
	initial
	begin
		#100000;
		miscompares++;
		conclude();
	end

	// Main sequence: table of register accesses, then hand-written cases.
	initial
	begin
		repeat (10) @(posedge clk_sys);
		#1;
		reset = 1'b0;
		check("oe allow", 8'h01, {7'h0, port_bit_b_oe_allow});
		check("t1 count", 8'h00, timer_one_count);
		foreach (rd_ops[i]) op_chk("reset value", rd_ops[i], 4'h0, 4'h0, 1'b0);
		foreach (rows[i]) op_chk("row", rows[i][11:8], rows[i][7:4], rows[i][3:0], 1'b0);
		check("pin oe", 8'h01, {7'h0, counter_pin_zero_oe});
		$display("Test registers done");
		ack(3'h0);
		ram_backup = 1'b1;
		ack(3'h0);
		ram_backup = 1'b0;
		foreach (rd_ops[i]) op_chk("backup value", rd_ops[i], 4'h0, kept[i], 1'b0);
		$display("Test back-up done");
		op_chk("t2 run", dtc_pkg::DTC_OP_WR_TMR2, 4'h7, 4'h0, 1'b0);
		wait_hi(3, 10, seen);
		check("pulse off", 8'h00, {7'h0, seen});
		op_chk("t2 stop", dtc_pkg::DTC_OP_WR_TMR2, 4'h3, 4'h0, 1'b0);
		held = timer_two_count;
		wait_hi(3, 6, seen);
		check("t2 hold", held, timer_two_count);
		op_chk("t2 skip", dtc_pkg::DTC_OP_SKIP_T2, 4'h0, 4'h0, 1'b1);
		op_chk("t2 skip used", dtc_pkg::DTC_OP_SKIP_T2, 4'h0, 4'h0, 1'b0);
		op_chk("t2 enable", dtc_pkg::DTC_OP_WR_IRQ_EN, 4'h8, 4'h0, 1'b0);
		op_chk("t2 pulse", dtc_pkg::DTC_OP_WR_TMR2, 4'hf, 4'h0, 1'b0);
		wait_hi(1, 12, seen);
		check("t2 irq", 8'h01, {7'h0, seen});
		wait_hi(3, 12, seen);
		check("pulse on", 8'h01, {7'h0, seen});
		op_chk("t2 no skip", dtc_pkg::DTC_OP_SKIP_T2, 4'h0, 4'h0, 1'b0);
		op_chk("t2 halt", dtc_pkg::DTC_OP_WR_TMR2, 4'h3, 4'h0, 1'b0);
		wait_hi(1, 3, seen);
		ack(3'h2);
		check("t2 irq clear", 8'h00, {7'h0, irq_timer_two});
		$display("Test timer two done");
		op_chk("t1 enable", dtc_pkg::DTC_OP_WR_IRQ_EN, 4'h4, 4'h0, 1'b0);
		op_chk("t1 run", dtc_pkg::DTC_OP_WR_TMR1, 4'h5, 4'h0, 1'b0);
		wait_hi(0, 12, seen);
		check("prescaler stopped", 8'h00, {7'h0, seen});
		op_chk("prescaler on", dtc_pkg::DTC_OP_WR_PRESC, 4'h1, 4'h0, 1'b0);
		wait_hi(0, 24, seen);
		check("t1 irq", 8'h01, {7'h0, seen});
		op_chk("t1 no skip", dtc_pkg::DTC_OP_SKIP_T1, 4'h0, 4'h0, 1'b0);
		wait_hi(4, 30, seen);
		check("pulse one off", 8'h00, {7'h0, seen});
		op_chk("t1 pulse", dtc_pkg::DTC_OP_WR_TMR1, 4'hd, 4'h0, 1'b0);
		wait_hi(4, 30, seen);
		check("pulse one on", 8'h01, {7'h0, seen});
		$display("Test timer one done");
		// Timer one counts rising edges of pin one, timer two falling edges of pin zero.
		op_chk("t1 pin src", dtc_pkg::DTC_OP_WR_TMR1, 4'h6, 4'h0, 1'b0);
		op_chk("t2 pin src", dtc_pkg::DTC_OP_WR_TMR2, 4'h6, 4'h0, 1'b0);
		held = timer_two_count;
		held_b = timer_one_count;
		pulse_req = 1'b1;
		wait_hi(0, 6, seen);
		check("pin1 rise", (held_b == 8'h00) ? timer_one_reload : held_b - 8'h01,
			timer_one_count);
		check("pin0 rise", held, timer_two_count);
		pulse_req = 1'b0;
		wait_hi(0, 6, seen);
		check("pin1 fall", (held_b == 8'h00) ? timer_one_reload : held_b - 8'h01,
			timer_one_count);
		check("pin0 fall", (held == 8'h00) ? timer_two_reload : held - 8'h01,
			timer_two_count);
		$display("Test counter pins done");
		op_chk("ext enable", dtc_pkg::DTC_OP_WR_IRQ_EN, 4'h1, 4'h0, 1'b0);
		op_chk("trig rise", dtc_pkg::DTC_OP_WR_TRIG, 4'hc, 4'h0, 1'b0);
		wait_hi(2, 5, seen);
		ack(3'h4);
		trig_level = 1'b1;
		wait_hi(2, 10, seen);
		check("ext rise", 8'h01, {7'h0, seen});
		op_chk("pin level", dtc_pkg::DTC_OP_SKIP_PIN, 4'h0, 4'h0, 1'b1);
		op_chk("ext no skip", dtc_pkg::DTC_OP_SKIP_EXT0, 4'h0, 4'h0, 1'b0);
		ack(3'h4);
		trig_level = 1'b0;
		wait_hi(2, 10, seen);
		check("ext single", 8'h00, {7'h0, seen});
		op_chk("trig both", dtc_pkg::DTC_OP_WR_TRIG, 4'he, 4'h0, 1'b0);
		trig_level = 1'b1;
		wait_hi(2, 6, seen);
		ack(3'h4);
		trig_level = 1'b0;
		wait_hi(2, 10, seen);
		check("ext both", 8'h01, {7'h0, seen});
		op_chk("trig off", dtc_pkg::DTC_OP_WR_TRIG, 4'h6, 4'h0, 1'b0);
		wait_hi(2, 5, seen);
		ack(3'h4);
		trig_level = 1'b1;
		wait_hi(2, 10, seen);
		check("ext gated", 8'h00, {7'h0, seen});
		$display("Test trigger done");
		conclude();
	end
endmodule
